// ==== hdl/lfs_pkg.sv ====
/*
  shared constants, enumerations and carrier structs of the linefeed state supervisor.
  assumes a single 10 MHz system clock and a monitor that delivers one sample strobe
  per refresh of line voltage, current and die temperature.
*/
package lfs_pkg;
  // clock rate and monitor refresh rate
  localparam int CLK_HZ = 32'h0098_9680;
  localparam int MON_RATE_HZ = 32'h0000_07d0;
  // longest gap between monitor samples, rounded down to whole cycles
  localparam int MON_PERIOD_CYC = CLK_HZ / MON_RATE_HZ;
  // die temperature limits in degrees
  localparam logic [7:0] TJ_LIMIT_LO = 8'h91;
  localparam logic [7:0] TJ_LIMIT_HI = 8'hc8;
  // data widths
  localparam int VAL_W = 32'h0000_000c;
  localparam int DEB_W = 32'h0000_0008;
  // adaptive ringing amplitude step and floor
  localparam logic [7:0] AMP_STEP = 8'h08;
  localparam logic [7:0] AMP_FLOOR = 8'h10;
  // interrupt flag bit positions
  localparam int IRQ_PWR = 32'h0000_0000;
  localparam int IRQ_LOOP = 32'h0000_0001;
  localparam int IRQ_GKEY = 32'h0000_0002;

  // linefeed operating states
  typedef enum logic [3:0] {
    LFS_OPEN = 4'h0,
    LFS_FWD_ACT = 4'h1,
    LFS_REV_ACT = 4'h2,
    LFS_FWD_OHT = 4'h3,
    LFS_REV_OHT = 4'h4,
    LFS_TIP_OPEN = 4'h5,
    LFS_RING_OPEN = 4'h6,
    LFS_RINGING = 4'h7,
    LFS_DIAG = 4'h8
  } lfs_state_e;

  // ringing modes and waveforms
  typedef enum logic [1:0] {
    LFS_RM_BALANCED = 2'h0,
    LFS_RM_UNBALANCED = 2'h1,
    LFS_RM_LOW_POWER_RINGING = 2'h2
  } lfs_ring_mode_e;
  typedef enum logic {LFS_WAVE_SINE = 1'h0, LFS_WAVE_TRAP = 1'h1} lfs_wave_e;

  // detector thresholds and debounce length in samples
  typedef struct packed {
    logic [VAL_W-1:0] thr_on;
    logic [VAL_W-1:0] thr_off;
    logic [DEB_W-1:0] deb;
  } lfs_det_cfg_s;

  // ringing generator setup
  typedef struct packed {
    lfs_wave_e wave;
    lfs_ring_mode_e mode;
    logic adaptive_en;
    logic [15:0] freq_step;
    logic [7:0] amp;
    logic signed [15:0] offset;
    logic [15:0] cad_on;
    logic [15:0] cad_off;
  } lfs_ring_cfg_s;

  // line driver controls
  typedef struct packed {
    logic hi_z;
    logic tip_en;
    logic ring_en;
    logic rev_pol;
    logic audio_en;
    logic superv_en;
    logic ringing;
    lfs_ring_mode_e ring_mode;
  } lfs_drive_s;

  // driver reset value: everything off, outputs high impedance
  localparam lfs_drive_s DRIVE_RST = '{1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0,
                                       LFS_RM_BALANCED};
endpackage

// ==== hdl/lfs_sync.sv ====
/*
  two flip-flop synchroniser for levels arriving from pins.
  assumes the inputs are quasi-static levels; pulses shorter than a clock may be lost.
*/
`timescale 1ns/10ps
module lfs_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  // first and second stage
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lfs_sync_st_s;
  lfs_sync_st_s st_r;
  lfs_sync_st_s st_nxt;

  // shift one stage per clock
  always_comb
  begin
    st_nxt.s1 = d_in;
    st_nxt.s2 = st_r.s1;
  end

  // state register
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign q_out = st_r.s2;
endmodule

// ==== hdl/lfs_detector.sv ====
/*
  hysteresis comparator with debounce filter, used for loop closure and ground key.
  assumes value and sample strobe come from monitor logic on the same clock.
*/
`timescale 1ns/10ps
module lfs_detector
  import lfs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic sample_in,
  input wire logic [VAL_W-1:0] value_in,
  input wire lfs_det_cfg_s cfg_in,
  output logic status_out,
  output logic event_out
);
  // comparator state, reported status, change pulse, debounce count
  typedef struct packed {
    logic hyst;
    logic stat;
    logic evt;
    logic [DEB_W-1:0] cnt;
  } lfs_det_st_s;
  lfs_det_st_s st_r;
  lfs_det_st_s st_nxt;

  // compare, then debounce on each monitor sample
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.evt = 1'b0;
    if (!enable_in)
    begin
      // supervision powered down: detector held idle
      st_nxt = '0;
    end
    else if (sample_in)
    begin
      // two thresholds give hysteresis
      if (!st_r.hyst && value_in >= cfg_in.thr_on)
        st_nxt.hyst = 1'b1;
      else if (st_r.hyst && value_in < cfg_in.thr_off)
        st_nxt.hyst = 1'b0;
      // raw result must hold for deb samples before status moves
      if (st_nxt.hyst == st_r.stat)
        st_nxt.cnt = '0;
      else if ({1'b0, st_r.cnt} + 9'h001 >= {1'b0, cfg_in.deb})
      begin
        st_nxt.stat = st_nxt.hyst;
        st_nxt.evt = 1'b1;
        st_nxt.cnt = '0;
      end
      else
        st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  // state register
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign status_out = st_r.stat;
  assign event_out = st_r.evt;

  // hysteresis holds below the upper threshold
  chk_hyst_holds_low: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    enable_in && sample_in && !st_r.hyst && value_in < cfg_in.thr_on |=> !st_r.hyst)
    else $error("detector left idle below upper threshold");
  // status rises only with an event pulse
  chk_status_event: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(st_r.stat) |-> st_r.evt)
    else $error("status rose without event");
  // no status change while counter is short of debounce length
  chk_deb_wait: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    enable_in && sample_in && {1'b0, st_r.cnt} + 9'h001 < {1'b0, cfg_in.deb}
    |=> $stable(st_r.stat))
    else $error("status changed before debounce expired");
endmodule

// ==== hdl/lfs_supervisor.sv ====
/*
  linefeed state supervisor: linefeed state, fault protection, loop and ground key
  detection, interrupt flags and ringing waveform sequencing for one channel.
  assumes fault pins are asynchronous levels, monitor data arrive on clk_sys_in,
  and the host drives the control ports from logic on the same clock.
*/
// Summary of operation
// - fault or overpower forces open, raises alarm
// - alarm maskable; auto open should stay enabled
// - total power, foreign fault, thermal all trip
// - over junction limit shuts down, 145/200
// - reset starts in the open state
// - open: high impedance, supervision off, no audio
// - open is high impedance during diagnostics
// - active states: feed, audio, detectors, polarity
// - on-hook transmission keeps feed and audio
// - tip open drives ring only, detectors on
// - ring open drives tip only, detectors on
// - ringing drives signal, optional dc offset
// - diagnostics state enables diagnostic resources
// - loop closure: two thresholds, then debounce
// - loop status continuous, maskable interrupt flag
// - ground key: own thresholds and debounce
// - ground key status and own flag
// - sine or trapezoid, programmable frequency, cadence, offset
// - balanced, unbalanced, low power ringing modes
// - adaptive ringing lowers amplitude on overpower
// - host selects one of nine states
// - monitor refresh at 2 kHz or faster
`timescale 1ns/10ps
module lfs_supervisor
  import lfs_pkg::*;
#(
  parameter int MON_TIMEOUT_CYC = MON_PERIOD_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic state_wr_in,
  input wire lfs_state_e state_sel_in,
  input wire logic auto_open_en_in,
  input wire logic total_power_over_in,
  input wire logic foreign_fault_in,
  input wire logic sample_in,
  input wire logic [VAL_W-1:0] loop_current_in,
  input wire logic [VAL_W-1:0] long_current_in,
  input wire logic [7:0] die_temp_in,
  input wire lfs_det_cfg_s loop_cfg_in,
  input wire lfs_det_cfg_s gkey_cfg_in,
  input wire lfs_ring_cfg_s ring_cfg_in,
  input wire logic [2:0] irq_mask_in,
  input wire logic [2:0] irq_clr_in,
  output lfs_state_e state_out,
  output lfs_drive_s drive_out,
  output logic diag_res_out,
  output logic shutdown_out,
  output logic loop_status_out,
  output logic gkey_status_out,
  output logic [2:0] irq_flags_out,
  output logic irq_out,
  output logic signed [15:0] ring_level_out,
  output logic [7:0] ring_amp_out,
  output logic mon_stale_out
);
  // whole module state
  typedef struct packed {
    lfs_state_e state;
    logic diag;
    logic [2:0] flags;
    logic trip_d;
    logic [7:0] amp;
    logic [23:0] phase;
    logic [15:0] cad_cnt;
    logic cad_on;
    logic [15:0] stale_cnt;
    logic stale;
    logic shut;
    logic irq;
    logic signed [15:0] lvl;
    lfs_drive_s drive;
  } lfs_sup_s;
  lfs_sup_s st_r;
  lfs_sup_s st_nxt;

  logic [1:0] pins_s; // synchronised fault pins
  logic pwr_over; // total power exceeded
  logic foreign; // foreign current or voltage on the leads
  logic therm; // die over junction limit
  logic [7:0] tj_limit; // state-dependent junction limit
  logic adapt_ok; // overpower may be absorbed by amplitude steps
  logic trip; // protective intervention requested
  logic lc_stat; // loop closure status
  logic lc_evt; // loop closure change
  logic gk_stat; // ground key status
  logic gk_evt; // ground key change
  logic [5:0] m6; // folded phase
  logic [11:0] sq; // parabola product
  logic [5:0] shape; // waveform magnitude before amplitude
  logic [13:0] mag; // scaled magnitude
  logic signed [15:0] wave_lvl; // signed ringing sample with offset
  logic [15:0] cad_lim; // length of current cadence phase

  // fault pins come from the analog side
  lfs_sync #(
    .W(2)
  ) u_pin_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .d_in({foreign_fault_in, total_power_over_in}),
    .q_out(pins_s)
  );

  // loop closure detector on loop current
  lfs_detector u_loop_det (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .enable_in(st_r.drive.superv_en),
    .sample_in(sample_in),
    .value_in(loop_current_in),
    .cfg_in(loop_cfg_in),
    .status_out(lc_stat),
    .event_out(lc_evt)
  );

  // ground key detector on longitudinal current
  lfs_detector u_gkey_det (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .enable_in(st_r.drive.superv_en),
    .sample_in(sample_in),
    .value_in(long_current_in),
    .cfg_in(gkey_cfg_in),
    .status_out(gk_stat),
    .event_out(gk_evt)
  );

  // line driver controls for a state
  function automatic lfs_drive_s drive_of(input lfs_state_e s, input lfs_ring_mode_e rm);
    lfs_drive_s d;
    d = DRIVE_RST;
    case (s)
      LFS_OPEN: d = DRIVE_RST;
      LFS_FWD_ACT, LFS_REV_ACT:
      begin
        // full feed, audio and supervision
        d.hi_z = 1'b0;
        d.tip_en = 1'b1;
        d.ring_en = 1'b1;
        d.audio_en = 1'b1;
        d.superv_en = 1'b1;
        d.rev_pol = (s == LFS_REV_ACT);
      end
      LFS_FWD_OHT, LFS_REV_OHT:
      begin
        // on-hook feed and audio
        d.hi_z = 1'b0;
        d.tip_en = 1'b1;
        d.ring_en = 1'b1;
        d.audio_en = 1'b1;
        d.rev_pol = (s == LFS_REV_OHT);
      end
      LFS_TIP_OPEN:
      begin
        // ring lead fed only, forward ground start
        d.hi_z = 1'b0;
        d.ring_en = 1'b1;
        d.superv_en = 1'b1;
      end
      LFS_RING_OPEN:
      begin
        // tip lead fed only, reverse ground start
        d.hi_z = 1'b0;
        d.tip_en = 1'b1;
        d.rev_pol = 1'b1;
        d.superv_en = 1'b1;
      end
      LFS_RINGING:
      begin
        // ringing across both leads in the chosen mode
        d.hi_z = 1'b0;
        d.tip_en = 1'b1;
        d.ring_en = 1'b1;
        d.ringing = 1'b1;
        d.ring_mode = rm;
      end
      LFS_DIAG: d = DRIVE_RST;
      default: d = DRIVE_RST;
    endcase
    return d;
  endfunction

  // fault causes
  always_comb
  begin
    pwr_over = pins_s[0];
    foreign = pins_s[1];
    // ringing runs with the higher junction limit
    tj_limit = (st_r.state == LFS_RINGING) ? TJ_LIMIT_HI : TJ_LIMIT_LO;
    therm = (die_temp_in >= tj_limit);
    // adaptive ringing takes overpower until the floor is reached
    adapt_ok = (st_r.state == LFS_RINGING) && ring_cfg_in.adaptive_en &&
               (st_r.amp > AMP_FLOOR);
    trip = (pwr_over && !adapt_ok) || foreign || therm;
  end

  // ringing waveform from phase, shape and amplitude
  always_comb
  begin
    // fold phase into a rising quarter, 0 to 63
    m6 = st_r.phase[22] ? ~st_r.phase[21:16] : st_r.phase[21:16];
    // operands widened first so the product keeps all twelve bits
    sq = {6'h00, m6} * (12'h07e - {6'h00, m6});
    if (ring_cfg_in.wave == LFS_WAVE_SINE)
      shape = sq[11:6];
    else
      shape = m6[5] ? 6'h3f : {m6[4:0], 1'b0};
    mag = {8'h00, shape} * {6'h00, st_r.amp};
    // second half of the cycle is negative, then dc offset is added
    if (st_r.phase[23])
      wave_lvl = 16'(ring_cfg_in.offset - $signed({2'h0, mag}));
    else
      wave_lvl = 16'(ring_cfg_in.offset + $signed({2'h0, mag}));
    cad_lim = st_r.cad_on ? ring_cfg_in.cad_on : ring_cfg_in.cad_off;
  end

  // next state of the supervisor
  always_comb
  begin
    st_nxt = st_r;
    // host selection; codes past the last state are ignored
    if (state_wr_in && state_sel_in <= LFS_DIAG)
      st_nxt.state = state_sel_in;
    // protective move to open wins over a host write
    if (auto_open_en_in && trip)
      st_nxt.state = LFS_OPEN;
    // diagnostic resources stay with open as the high impedance test state
    if (st_nxt.state == LFS_DIAG)
      st_nxt.diag = 1'b1;
    else if (st_nxt.state != LFS_OPEN)
      st_nxt.diag = 1'b0;
    st_nxt.shut = therm;
    st_nxt.trip_d = trip;
    // sticky flags: a new event wins over a clear in the same cycle
    st_nxt.flags = st_r.flags & ~irq_clr_in;
    st_nxt.flags[IRQ_PWR] = st_nxt.flags[IRQ_PWR] | (trip && !st_r.trip_d);
    st_nxt.flags[IRQ_LOOP] = st_nxt.flags[IRQ_LOOP] | lc_evt;
    st_nxt.flags[IRQ_GKEY] = st_nxt.flags[IRQ_GKEY] | gk_evt;
    st_nxt.irq = |(st_nxt.flags & irq_mask_in);
    // ringing sequencer
    if (st_nxt.state == LFS_RINGING && st_r.state != LFS_RINGING)
    begin
      // entry: full amplitude, cadence starts in its on phase
      st_nxt.amp = ring_cfg_in.amp;
      st_nxt.phase = '0;
      st_nxt.cad_cnt = '0;
      st_nxt.cad_on = 1'b1;
    end
    else if (st_nxt.state == LFS_RINGING)
    begin
      st_nxt.phase = st_r.phase + {8'h00, ring_cfg_in.freq_step};
      if (sample_in)
      begin
        // cadence counted in monitor samples; zero off time rings steadily
        if (st_r.cad_cnt + 16'h0001 >= cad_lim)
        begin
          st_nxt.cad_cnt = '0;
          if (!(st_r.cad_on && ring_cfg_in.cad_off == 16'h0000))
            st_nxt.cad_on = !st_r.cad_on;
        end
        else
          st_nxt.cad_cnt = st_r.cad_cnt + 16'h0001;
        // step the amplitude down while the feed draws too much
        if (adapt_ok && pwr_over)
        begin
          if (st_r.amp - AMP_STEP > AMP_FLOOR && st_r.amp > AMP_STEP)
            st_nxt.amp = st_r.amp - AMP_STEP;
          else
            st_nxt.amp = AMP_FLOOR;
        end
      end
    end
    // ringing sample goes out only in the on phase of the cadence
    if (st_r.state == LFS_RINGING && st_r.cad_on)
      st_nxt.lvl = wave_lvl;
    else
      st_nxt.lvl = '0;
    // monitor refresh watchdog
    if (sample_in)
    begin
      st_nxt.stale_cnt = '0;
      st_nxt.stale = 1'b0;
    end
    else if (32'(st_r.stale_cnt) + 1 >= MON_TIMEOUT_CYC)
      st_nxt.stale = 1'b1;
    else
      st_nxt.stale_cnt = st_r.stale_cnt + 16'h0001;
    st_nxt.drive = drive_of(st_nxt.state, ring_cfg_in.mode);
  end

  // state register; reset lands in open with drivers off
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_r <= '0;
      st_r.state <= LFS_OPEN;
      st_r.drive <= DRIVE_RST;
    end
    else
      st_r <= st_nxt;
  end

  // outputs from the state register
  assign state_out = st_r.state;
  assign drive_out = st_r.drive;
  assign diag_res_out = st_r.diag;
  assign shutdown_out = st_r.shut;
  assign loop_status_out = lc_stat;
  assign gkey_status_out = gk_stat;
  assign irq_flags_out = st_r.flags;
  assign irq_out = st_r.irq;
  assign ring_level_out = st_r.lvl;
  assign ring_amp_out = st_r.amp;
  assign mon_stale_out = st_r.stale;

  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  chk_fault_opens: assert property (
    auto_open_en_in && trip |=> st_r.state == LFS_OPEN && st_r.drive.hi_z)
    else $error("fault did not force open");
  chk_alarm_flag: assert property (
    trip && !st_r.trip_d |=> st_r.flags[IRQ_PWR])
    else $error("power alarm flag not set");
  chk_irq_masked: assert property (
    irq_mask_in == 3'h0 |=> !irq_out)
    else $error("interrupt raised while masked");
  chk_thermal_shut: assert property (
    die_temp_in >= tj_limit |=> shutdown_out ##0 (!$past(auto_open_en_in) ||
      st_r.state == LFS_OPEN))
    else $error("thermal limit without shutdown");
  chk_open_hiz: assert property (
    st_r.state == LFS_OPEN |-> st_r.drive.hi_z && !st_r.drive.superv_en &&
      !st_r.drive.audio_en ##1 !lc_evt)
    else $error("open state not quiet");
  chk_tip_open: assert property (
    st_r.state == LFS_TIP_OPEN |-> !st_r.drive.tip_en && st_r.drive.ring_en &&
      st_r.drive.superv_en)
    else $error("tip open drive wrong");
  chk_state_write: assert property (
    state_wr_in && state_sel_in == LFS_REV_ACT && !trip |=> st_r.state == LFS_REV_ACT
      && st_r.drive.rev_pol)
    else $error("state write not taken");
  chk_flag_sticky: assert property (
    st_r.flags[IRQ_LOOP] && !irq_clr_in[IRQ_LOOP] |=> st_r.flags[IRQ_LOOP])
    else $error("loop flag lost");
  chk_adapt_step: assert property (
    adapt_ok && pwr_over && sample_in && st_r.amp > 8'h20 && !state_wr_in && !trip
    |=> st_r.amp == $past(st_r.amp) - AMP_STEP)
    else $error("adaptive step wrong");
  chk_mon_fresh: assert property (
    sample_in |=> !mon_stale_out [*2])
    else $error("stale flag despite sample");

  cov_fault_open: cover property (st_r.state == LFS_FWD_ACT ##1 st_r.state == LFS_OPEN);
  cov_loop_irq: cover property (lc_evt ##1 irq_out);
  cov_ring_adapt: cover property (st_r.state == LFS_RINGING && st_r.amp == AMP_FLOOR);
  cov_gkey: cover property ($rose(gk_stat));
endmodule

// ==== bench/lfs_line_model.sv ====
/*
  model of the analog line and subscriber terminal seen through the monitor:
  loop and longitudinal current levels plus the monitor sample strobe.
  assumes the bench sets the current levels and the supervisor's drive state
  decides whether any current flows at all.
*/
`timescale 1ns/10ps
module lfs_line_model
  import lfs_pkg::*;
#(
  parameter int SAMPLE_CYC = 20
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire lfs_drive_s drive_in,
  input wire logic [VAL_W-1:0] loop_lvl_in,
  input wire logic [VAL_W-1:0] long_lvl_in,
  output logic sample_out,
  output logic [VAL_W-1:0] loop_current_out,
  output logic [VAL_W-1:0] long_current_out
);
  // cycles since the last strobe
  int cnt;
  // line is fed when a lead is driven and the output is not high impedance
  logic fed;

  // an open channel draws no current whatever the terminal does
  assign fed = !drive_in.hi_z && (drive_in.tip_en || drive_in.ring_en);
  assign loop_current_out = fed ? loop_lvl_in : '0;
  assign long_current_out = fed ? long_lvl_in : '0;

  // one strobe per refresh, well inside the stale watchdog
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt <= 0;
      sample_out <= 1'h0;
    end
    else
    begin
      cnt <= (cnt == SAMPLE_CYC - 1) ? 0 : cnt + 1;
      sample_out <= (cnt == SAMPLE_CYC - 1);
    end
  end
endmodule

// ==== bench/testbench.sv ====
/*
  self-checking bench of the linefeed state supervisor: states, detectors,
  fault protection and thermal shutdown.
  assumes the line model provides monitor samples every 20 cycles.
*/
`timescale 1ns/10ps
module testbench;
  import lfs_pkg::*;
  // expected {hi_z,tip,ring,rev,audio,superv,ringing} per state and bits that matter
  localparam logic [6:0] EXP_D [9] = '{7'h40, 7'h36, 7'h3e, 7'h34, 7'h3c, 7'h12, 7'h22,
                                       7'h31, 7'h40};
  localparam logic [6:0] CARE_D [9] = '{7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h73, 7'h73,
                                        7'h71, 7'h7f};
  logic clk_sys_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic state_wr = 1'h0;
  lfs_state_e state_sel = LFS_OPEN;
  logic auto_open = 1'h1;
  logic pwr_over = 1'h0;
  logic foreign = 1'h0;
  logic [7:0] temp = 8'h19;
  lfs_det_cfg_s det_cfg = '{12'h080, 12'h040, 8'h03};
  lfs_ring_cfg_s ring_cfg = '{LFS_WAVE_SINE, LFS_RM_BALANCED, 1'h0, 16'h0100, 8'h40,
                              16'sh0000, 16'h0004, 16'h0000};
  logic [2:0] mask = 3'h7;
  logic [2:0] clr = 3'h0;
  logic [11:0] loop_lvl = 12'h000;
  logic [11:0] long_lvl = 12'h000;
  logic sample, diag_res, shut, loop_st, gkey_st, irq, stale;
  logic [11:0] loop_cur, long_cur;
  logic [15:0] ring_lvl;
  logic [7:0] amp;
  logic [2:0] flags;
  lfs_state_e state;
  lfs_drive_s drv;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;

  lfs_supervisor #(.MON_TIMEOUT_CYC(50)) i_lfs_supervisor (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .state_wr_in(state_wr),
    .state_sel_in(state_sel), .auto_open_en_in(auto_open), .total_power_over_in(pwr_over),
    .foreign_fault_in(foreign), .sample_in(sample), .loop_current_in(loop_cur),
    .long_current_in(long_cur), .die_temp_in(temp), .loop_cfg_in(det_cfg),
    .gkey_cfg_in(det_cfg), .ring_cfg_in(ring_cfg), .irq_mask_in(mask), .irq_clr_in(clr),
    .state_out(state), .drive_out(drv), .diag_res_out(diag_res), .shutdown_out(shut),
    .loop_status_out(loop_st), .gkey_status_out(gkey_st), .irq_flags_out(flags),
    .irq_out(irq), .ring_level_out(ring_lvl), .ring_amp_out(amp), .mon_stale_out(stale));

  lfs_line_model i_lfs_line_model (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .drive_in(drv), .loop_lvl_in(loop_lvl),
    .long_lvl_in(long_lvl), .sample_out(sample), .loop_current_out(loop_cur),
    .long_current_out(long_cur));

  // 10 MHz system clock
  always #50 clk_sys_in = ~clk_sys_in;

  // hang guard
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      final_report();
    end
  end

  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // wait whole cycles, then step clear of the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  // one-cycle state write
  task automatic wr(input lfs_state_e s);
    @(posedge clk_sys_in);
    state_sel <= s;
    state_wr <= 1'h1;
    @(posedge clk_sys_in);
    state_wr <= 1'h0;
    step(1);
  endtask

  // let n monitor samples pass, then until flags have landed
  task automatic samp(input int n);
    repeat (n) @(posedge sample);
    step(2);
  endtask

  // clear every interrupt flag
  task automatic clr_all;
    @(posedge clk_sys_in);
    clr <= 3'h7;
    @(posedge clk_sys_in);
    clr <= 3'h0;
    step(1);
  endtask

  // set the line current seen by detector b (1 loop, 2 ground key)
  task automatic lvl(input int b, input logic [11:0] v);
    @(posedge clk_sys_in);
    if (b == 1)
      loop_lvl <= v;
    else
      long_lvl <= v;
  endtask

  // walk every state code, then an illegal one
  task automatic t_states;
    for (int i = 0; i < 9; i++)
    begin
      wr(lfs_state_e'(i));
      chk(state, 16'(i));
      chk(drv[8:2] & CARE_D[i], EXP_D[i]);
      if (i == 7)
        chk(amp, 8'h40);
    end
    chk(diag_res, 1'h1);
    wr(lfs_state_e'(4'h9));
    chk(state, LFS_DIAG);
    wr(LFS_OPEN);
    chk(drv.hi_z, 1'h1);
  endtask

  // hysteresis and debounce of one detector
  task automatic t_det(input int b);
    wr(LFS_FWD_ACT);
    lvl(b, 12'h100);
    samp(2);
    chk((b == 1) ? loop_st : gkey_st, 1'h0);
    samp(1);
    chk((b == 1) ? loop_st : gkey_st, 1'h1);
    chk({flags[b], irq}, 2'h3);
    clr_all();
    lvl(b, 12'h060);
    samp(4);
    chk({(b == 1) ? loop_st : gkey_st, flags[b]}, 2'h2);
    lvl(b, 12'h020);
    samp(3);
    chk({(b == 1) ? loop_st : gkey_st, flags[b]}, 2'h1);
    clr_all();
  endtask

  // fault pins, masking and the auto open switch
  task automatic t_fault;
    wr(LFS_FWD_ACT);
    mask <= 3'h0;
    foreign <= 1'h1;
    step(5);
    chk({state, flags[0], irq}, {LFS_OPEN, 2'h2});
    wr(LFS_FWD_ACT);
    chk(state, LFS_OPEN);
    mask <= 3'h7;
    foreign <= 1'h0;
    step(2);
    chk(irq, 1'h1);
    clr_all();
    chk(flags, 3'h0);
    wr(LFS_FWD_ACT);
    pwr_over <= 1'h1;
    step(5);
    chk({state, flags[0]}, {LFS_OPEN, 1'h1});
    auto_open <= 1'h0;
    pwr_over <= 1'h0;
    clr_all();
    wr(LFS_FWD_ACT);
    pwr_over <= 1'h1;
    step(5);
    chk({state, flags[0]}, {LFS_FWD_ACT, 1'h1});
    pwr_over <= 1'h0;
    clr_all();
    // re-arm only once the synchronised pin has fallen
    auto_open <= 1'h1;
  endtask

  // junction limit depends on the state
  task automatic t_therm;
    temp <= 8'h90;
    step(3);
    chk(state, LFS_FWD_ACT);
    temp <= 8'h91;
    step(3);
    chk({state, shut}, {LFS_OPEN, 1'h1});
    temp <= 8'h19;
    wr(LFS_RINGING);
    temp <= 8'hc7;
    step(3);
    chk(state, LFS_RINGING);
    temp <= 8'hc8;
    step(3);
    chk(state, LFS_OPEN);
    temp <= 8'h19;
    clr_all();
  endtask

  // ringing entry level, mode and one adaptive amplitude step
  task automatic t_ring;
    ring_cfg <= '{LFS_WAVE_TRAP, LFS_RM_LOW_POWER_RINGING, 1'h1, 16'h0000, 8'h40,
                  16'sh0123, 16'h0004, 16'h0000};
    wr(LFS_RINGING);
    chk({drv.ring_mode, amp}, {LFS_RM_LOW_POWER_RINGING, 8'h40});
    chk(ring_lvl, 16'h0123);
    // raise the power pin on a sample edge so exactly one later sample sees it
    @(posedge sample);
    pwr_over <= 1'h1;
    samp(1);
    chk({state, amp, flags[0]}, {LFS_RINGING, 8'h38, 1'h0});
    pwr_over <= 1'h0;
    wr(LFS_OPEN);
  endtask

  // print counts and verdict, end the run
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'h1;
    step(1);
    chk({state, drv[8:2], flags}, {LFS_OPEN, 7'h40, 3'h0});
    t_states();
    t_det(1);
    t_det(2);
    t_fault();
    wr(LFS_FWD_ACT);
    t_therm();
    t_ring();
    chk(stale, 1'h0);
    final_report();
  end
endmodule
